// ==== common/rxq_cmd_pkg.sv ====
// constants for the receive queue command register block
package rxq_cmd_pkg;
  localparam logic [7:0]  RXQ_CMD_ADDR      = 8'h82;
  localparam logic [15:0] RXQ_CMD_RESET     = 16'h0000;
  // bits software may store directly (causes, burst and release handled apart)
  localparam logic [15:0] RXQ_CMD_RW_MASK   = 16'he3f6;
  localparam int          DUR_CAUSE_BIT     = 12;
  localparam int          BYTE_CAUSE_BIT    = 11;
  localparam int          FRAME_CAUSE_BIT   = 10;
  localparam int          IP_ALIGN_BIT      = 9;
  localparam int          DUR_EN_BIT        = 7;
  localparam int          BYTE_EN_BIT       = 6;
  localparam int          FRAME_EN_BIT      = 5;
  localparam int          AUTO_DEQ_BIT      = 4;
  localparam int          BURST_BIT         = 3;
  localparam int          RELEASE_BIT       = 0;
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          DUR_UNIT_NS       = 1000;
  localparam int          US_CYCLES         = (DUR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  US_LAST           = 8'(US_CYCLES - 1);
endpackage

// ==== core/receive_queue_command.sv ====
// receive queue command register: thresholds, causes, burst gate, release
// Functional notes
// (R1) bit 12 flags duration threshold as cause
// (R2) bit 11 flags byte threshold as cause
// (R3) bit 10 flags frame threshold as cause
// (R4) causes refresh on interrupt bit 13 write
// (R5) bit 9 adds two-byte IP alignment
// (R6) bit 7 enables duration threshold interrupt
// (R7) bit 6 enables byte threshold interrupt
// (R8) bit 5 enables frame threshold interrupt
// (R9) bit 4 auto-dequeues after frame read
// (R10) bit 3 write opens burst FIFO access
// (R11) burst blocks all other registers
// (R12) host clears bit 3 after burst
// (R13) bit 0 releases current errored frame
// (R14) release bit self-clears when memory freed
// (R15) software polls release bit before next frame
// (R16) duration threshold counted in microseconds
// (R17) host zeroes frame pointer before burst read
// (R18) blocked writes ignored, blocked reads zero
`timescale 1ns/1ps
`default_nettype none
module receive_queue_command #(
  parameter int FRAME_W = 8,
  parameter int BYTE_W  = 16,
  parameter int DUR_W   = 16
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [1:0]                reg_be_i,
  input  wire logic [15:0]               reg_wdata_i,
  output logic      [15:0]               reg_rdata_o,
  output logic                           reg_rvalid_o,
  output logic                           reg_blocked_o,
  input  wire logic                      isr_rx_ack_i,
  input  wire logic [FRAME_W-1:0]        rxq_frames_i,
  input  wire logic [BYTE_W-1:0]         rxq_bytes_i,
  input  wire logic [DUR_W-1:0]          duration_threshold_value_i,
  input  wire logic [BYTE_W-1:0]         byte_threshold_value_i,
  input  wire logic [FRAME_W-1:0]        frame_threshold_value_i,
  input  wire logic                      frame_read_done_i,
  input  wire logic                      release_done_i,
  output logic                           rx_irq_set_o,
  output logic                           ip_header_align_offset_en_o,
  output logic                           dequeue_o,
  output logic                           burst_active_o,
  output logic                           release_req_o
);
  import rxq_cmd_pkg::*;

  logic              rst_meta_r;
  logic              rst_sync_r;
  logic [15:0]       ctrl_r;
  logic [15:0]       ctrl_nxt;
  logic              burst_r;
  logic              burst_nxt;
  logic [2:0]        cause_r;
  logic [2:0]        cause_nxt;
  logic [7:0]        pre_r;
  logic [7:0]        pre_nxt;
  logic [DUR_W-1:0]  us_r;
  logic [DUR_W-1:0]  us_nxt;
  logic              hit_prev_r;
  logic              hit_prev_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              deq_r;
  logic              deq_nxt;
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic              wr_hit;
  logic [15:0]       wmask;
  logic [15:0]       view;
  logic [2:0]        exceed;
  logic [2:0]        armed;
  logic              hit;

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign wr_hit = reg_wr_i && (reg_addr_i == RXQ_CMD_ADDR);
  assign wmask  = {{8{reg_be_i[1]}}, {8{reg_be_i[0]}}};

  // threshold comparisons; "exceeds" is taken as strictly greater
  // the duration source only runs while a frame waits in the queue
  assign exceed[2] = (rxq_frames_i != '0) && (us_r > duration_threshold_value_i);    // (R16)
  assign exceed[1] = rxq_bytes_i > byte_threshold_value_i;
  assign exceed[0] = rxq_frames_i > frame_threshold_value_i;
  assign armed     = exceed & {ctrl_r[DUR_EN_BIT], ctrl_r[BYTE_EN_BIT], ctrl_r[FRAME_EN_BIT]}; // (R6) (R7) (R8)
  assign hit       = |armed;

  // register view: burst bit is write-only and reads zero
  always_comb begin
    view                  = ctrl_r;
    view[BURST_BIT]       = 1'b0;
    view[DUR_CAUSE_BIT]   = cause_r[2];                 // (R1)
    view[BYTE_CAUSE_BIT]  = cause_r[1];                 // (R2)
    view[FRAME_CAUSE_BIT] = cause_r[0];                 // (R3)
  end

  // control register and burst gate
  always_comb begin
    ctrl_nxt  = ctrl_r;
    burst_nxt = burst_r;
    // causes, burst and release never take the plain store path
    if (wr_hit) begin
      ctrl_nxt = (ctrl_r & ~(wmask & RXQ_CMD_RW_MASK)) | (reg_wdata_i & wmask & RXQ_CMD_RW_MASK);
      if (reg_be_i[0]) begin
        burst_nxt = reg_wdata_i[BURST_BIT];             // (R10) (R12)
      end
    end
    // the set wins if release completes in the cycle of a new request
    if (wr_hit && reg_be_i[0] && reg_wdata_i[RELEASE_BIT]) begin
      ctrl_nxt[RELEASE_BIT] = 1'b1;                     // (R13)
    end else if (release_done_i) begin
      ctrl_nxt[RELEASE_BIT] = 1'b0;                     // (R14)
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r  <= RXQ_CMD_RESET;
      burst_r <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      burst_r <= burst_nxt;
    end
  end

  // microsecond timer runs while the queue holds at least one frame
  // it saturates rather than wraps, so a stalled host still sees the crossing
  always_comb begin
    pre_nxt = pre_r;
    us_nxt  = us_r;
    if (rxq_frames_i == '0) begin
      pre_nxt = '0;
      us_nxt  = '0;
    end else if (pre_r == US_LAST) begin
      pre_nxt = '0;
      if (us_r != '1) begin
        us_nxt = us_r + 1'b1;                           // (R16)
      end
    end else begin
      pre_nxt = pre_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pre_r <= '0;
      us_r  <= '0;
    end else begin
      pre_r <= pre_nxt;
      us_r  <= us_nxt;
    end
  end

  // interrupt request on a new armed crossing; causes captured on acknowledge
  // no new request fires while any armed source stays over its threshold; all must drop to re-arm
  always_comb begin
    hit_prev_nxt = hit;
    irq_nxt      = hit && !hit_prev_r;                  // (R6) (R7) (R8)
    cause_nxt    = cause_r;
    if (isr_rx_ack_i) begin
      cause_nxt = armed;                                // (R4)
    end
    deq_nxt = frame_read_done_i && ctrl_r[AUTO_DEQ_BIT]; // (R9)
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hit_prev_r <= 1'b0;
      irq_r      <= 1'b0;
      cause_r    <= 3'h0;
      deq_r      <= 1'b0;
    end else begin
      hit_prev_r <= hit_prev_nxt;
      irq_r      <= irq_nxt;
      cause_r    <= cause_nxt;
      deq_r      <= deq_nxt;
    end
  end

  // read answer one cycle after the strobe; other offsets answer zero here,
  // the rest of the register file watches reg_blocked_o during a burst
  always_comb begin
    rvalid_nxt = reg_rd_i;
    rdata_nxt  = 16'h0000;
    if (reg_rd_i && (reg_addr_i == RXQ_CMD_ADDR)) begin
      rdata_nxt = view;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o                 = rdata_r;
  assign reg_rvalid_o                = rvalid_r;
  assign reg_blocked_o               = burst_r;          // (R11) (R18)
  assign rx_irq_set_o                = irq_r;
  assign ip_header_align_offset_en_o = ctrl_r[IP_ALIGN_BIT]; // (R5)
  assign dequeue_o                   = deq_r;
  assign burst_active_o              = burst_r;
  assign release_req_o               = ctrl_r[RELEASE_BIT];

  // bus, burst gate, release, cause, interrupt, dequeue and timer checks
  a_blocked_read_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R18)
    (reg_rd_i && burst_r && reg_addr_i != RXQ_CMD_ADDR) |=> (reg_rvalid_o && reg_rdata_o == 16'h0000))
    else $error("blocked read did not return zero");
  a_burst_open: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R10)
    (wr_hit && reg_be_i[0] && reg_wdata_i[BURST_BIT]) |=> (burst_active_o && reg_blocked_o))
    else $error("burst did not open on write");
  a_burst_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R10)
    (reg_rd_i && reg_addr_i == RXQ_CMD_ADDR) |=> !reg_rdata_o[BURST_BIT])
    else $error("write-only burst bit read back");
  a_release_set: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R13)
    (wr_hit && reg_be_i[0] && reg_wdata_i[RELEASE_BIT]) |=> release_req_o)
    else $error("release request not raised");
  a_release_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R14)
    (release_done_i && !(wr_hit && reg_be_i[0] && reg_wdata_i[RELEASE_BIT])) |=> !release_req_o)
    else $error("release bit did not self-clear");
  a_cause_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R4)
    isr_rx_ack_i |=> (cause_r == $past(armed)))
    else $error("causes not refreshed on acknowledge");
  a_cause_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R4)
    !isr_rx_ack_i |=> $stable(cause_r))
    else $error("causes changed without acknowledge");
  a_irq_needs_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R8)
    (exceed[0] && ctrl_r[FRAME_EN_BIT] && !hit_prev_r) |=> rx_irq_set_o)
    else $error("frame threshold interrupt missed");
  a_irq_disabled: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R7)
    (ctrl_r[7:5] == 3'h0) |=> !rx_irq_set_o)
    else $error("interrupt raised with all sources off");
  a_auto_dequeue: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R9)
    frame_read_done_i |=> (dequeue_o == $past(ctrl_r[AUTO_DEQ_BIT])))
    else $error("auto dequeue mismatch");
  a_us_tick: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R16)
    (rxq_frames_i != '0 && pre_r == US_LAST && us_r != '1 && rxq_frames_i != '0)
      |=> (us_r == $past(us_r) + 1'b1 || $past(rxq_frames_i) == '0))
    else $error("microsecond count did not advance");

  // threshold sources, timer, write, read and hold checks
  a_dur_irq: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R6)
    (exceed[2] && ctrl_r[DUR_EN_BIT] && !hit_prev_r) |=> rx_irq_set_o)
    else $error("duration threshold interrupt missed");
  a_byte_irq: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R7)
    (exceed[1] && ctrl_r[BYTE_EN_BIT] && !hit_prev_r) |=> rx_irq_set_o)
    else $error("byte threshold interrupt missed");
  a_irq_no_repeat: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R6)
    hit_prev_r |=> !rx_irq_set_o)
    else $error("interrupt repeated while a source stayed armed");
  a_dur_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R16)
    (rxq_frames_i == '0) |=> (us_r == '0))
    else $error("duration timer ran with an empty queue");
  a_us_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R16)
    (rxq_frames_i != '0 && pre_r != US_LAST) |=> (us_r == $past(us_r)))
    else $error("microsecond count moved between ticks");
  a_align_write: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R5)
    (wr_hit && reg_be_i[1]) |=> (ip_header_align_offset_en_o == $past(reg_wdata_i[IP_ALIGN_BIT])))
    else $error("alignment enable not stored");
  a_burst_close: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R12)
    (wr_hit && reg_be_i[0] && !reg_wdata_i[BURST_BIT]) |=> !reg_blocked_o)
    else $error("burst did not close on write of zero");
  a_burst_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R11)
    !wr_hit |=> $stable(burst_active_o))
    else $error("burst gate changed without a write");
  a_ctrl_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R5)
    (!wr_hit && !release_done_i) |=> $stable(ctrl_r))
    else $error("control bits changed without a write");
  a_release_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R14)
    (release_req_o && !release_done_i) |=> release_req_o)
    else $error("release bit dropped before memory freed");
  a_dequeue_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R9)
    !frame_read_done_i |=> !dequeue_o)
    else $error("dequeue without a finished frame read");
  a_read_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R18)
    !reg_rd_i |=> (!reg_rvalid_o && reg_rdata_o == 16'h0000))
    else $error("read answer without a read strobe");
  a_cause_view: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_r) // (R1) (R2) (R3)
    (reg_rd_i && reg_addr_i == RXQ_CMD_ADDR)
      |=> (reg_rdata_o[DUR_CAUSE_BIT] == $past(cause_r[2]) && reg_rdata_o[BYTE_CAUSE_BIT] == $past(cause_r[1])
        && reg_rdata_o[FRAME_CAUSE_BIT] == $past(cause_r[0])))
    else $error("cause bits not shown on read");
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
// host model driving the command register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       addr_o,
  output logic [1:0]       be_o,
  output logic [15:0]      wdata_o
);
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 8'h00;
    be_o    = 2'h0;
    wdata_o = 16'h0000;
  end
  // released data turns to its inverse so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    be_o    <= b;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
  task automatic poll_release(output logic [15:0] d);
    logic v;
    d = 16'h0001;
    for (int i = 0; i < 20 && d[0] !== 1'b0; i++) rd(8'h82, d, v);
  endtask
endmodule
`default_nettype wire

// ==== test/receive_queue_command_bench.sv ====
// bench for the receive queue command register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("unexpected %s exp %h seen %h", n, e, a); end end
module receive_queue_command_bench;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             ack = 1'b0;
  logic             frd = 1'b0;
  logic             rdone = 1'b0;
  logic [7:0]       frames = 8'h00;
  logic [15:0]      bytes = 16'h0000;
  wire logic        wr, rd, rvalid, blocked, irq, align, deq, burst, rel;
  wire logic [7:0]  addr;
  wire logic [1:0]  be;
  wire logic [15:0] wdata, rdata;
  int               fails = 0, cmp_count = 0, cyc = 0, irqs = 0, deqs = 0;
  always #5 clk = ~clk;
  host_model i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .be_o(be), .wdata_o(wdata));
  receive_queue_command i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .reg_blocked_o(blocked), .isr_rx_ack_i(ack), .rxq_frames_i(frames), .rxq_bytes_i(bytes),
    .duration_threshold_value_i(16'h0001), .byte_threshold_value_i(16'h0064),
    .frame_threshold_value_i(8'h03), .frame_read_done_i(frd), .release_done_i(rdone),
    .rx_irq_set_o(irq), .ip_header_align_offset_en_o(align), .dequeue_o(deq),
    .burst_active_o(burst), .release_req_o(rel));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // counts pulses and cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (irq !== 1'b0) irqs++;
    if (deq !== 1'b0) deqs++;
    if (cyc == 6000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // queue levels change only at a rising edge
  task automatic set_queue(input logic [7:0] f, input logic [15:0] q);
    @(posedge clk);
    frames <= f;
    bytes  <= q;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    i_host.rd(a, d, v);
    `CHK("read valid", 1'b1, v)
    `CHK("read data", e, d)
  endtask
  task automatic pulse_ack();
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask
  task automatic regs_case();
    rdchk(8'h82, 16'h0000);
    i_host.wr(8'h82, 2'h3, 16'hfff6);
    rdchk(8'h82, 16'he3f6);
    `CHK("align", 1'b1, align)
    i_host.wr(8'h82, 2'h1, 16'h0000);
    rdchk(8'h82, 16'he300);
    i_host.wr(8'h82, 2'h3, 16'h0000);
    rdchk(8'h84, 16'h0000);
    `CHK("align", 1'b0, align)
  endtask
  task automatic burst_case();
    i_host.wr(8'h82, 2'h2, 16'h0008);
    tick(1);
    `CHK("burst", 1'b0, burst)
    i_host.wr(8'h86, 2'h3, 16'h0000);
    i_host.wr(8'h82, 2'h1, 16'h0008);
    tick(1);
    `CHK("burst", 1'b1, burst)
    `CHK("blocked", 1'b1, blocked)
    rdchk(8'h86, 16'h0000);
    i_host.wr(8'h82, 2'h1, 16'h0000);
    tick(1);
    `CHK("blocked", 1'b0, blocked)
  endtask
  task automatic rel_case();
    logic [15:0] d;
    i_host.wr(8'h82, 2'h1, 16'h0001);
    tick(4);
    `CHK("release", 1'b1, rel)
    @(posedge clk);
    rdone <= 1'b1;
    @(posedge clk);
    rdone <= 1'b0;
    tick(2);
    `CHK("release", 1'b0, rel)
    i_host.poll_release(d);
    `CHK("release bit", 1'b0, d[0])
  endtask
  task automatic deq_case();
    int n;
    for (int k = 1; k >= 0; k--) begin
      i_host.wr(8'h82, 2'h1, 16'(k << 4));
      n = deqs;
      @(posedge clk);
      frd <= 1'b1;
      @(posedge clk);
      frd <= 1'b0;
      tick(2);
      `CHK("dequeues", n + k, deqs)
    end
  endtask
  task automatic quiet_case();
    int n;
    n = irqs;
    set_queue(8'h09, 16'h00c8);
    tick(300);
    `CHK("irq count", n, irqs)
    set_queue(8'h00, 16'h0000);
  endtask
  // strictly-greater edge case first, then one over the threshold
  task automatic thr_case(input int b);
    int n;
    n = irqs;
    set_queue((b == 7) ? 8'h01 : 8'h03, 16'h0064);
    i_host.wr(8'h82, 2'h1, 16'(1 << b));
    tick((b == 7) ? 150 : 5);
    `CHK("early irq", n, irqs)
    set_queue((b == 5) ? 8'h04 : frames, (b == 6) ? 16'h0065 : bytes);
    for (int i = 0; i < 150 && irqs == n; i++) @(posedge clk);
    tick(3);
    `CHK("irq count", n + 1, irqs)
    pulse_ack();
    rdchk(8'h82, 16'(1 << b) | 16'(1 << (b + 5)));
    set_queue(8'h00, 16'h0000);
    i_host.wr(8'h82, 2'h1, 16'h0000);
    pulse_ack();
    rdchk(8'h82, 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    regs_case();
    burst_case();
    rel_case();
    deq_case();
    quiet_case();
    for (int b = 5; b <= 7; b++) thr_case(b);
    report_and_stop();
  end
endmodule
`default_nettype wire
